// ===== verilog/fdp_pkg.sv
// Constants and types of the protection block.
// Assumes one 100 MHz clock; link pins are sampled, not clocked on.
package fdp_pkg;

  // One-time space geometry
  localparam int OTP_BYTES        = 2048;
  localparam int OTP_REGION_LOG2  = 6;
  localparam int OTP_REGIONS      = 32;
  localparam int OTP_UNIT_LOG2    = 4;
  localparam int OTP_UNITS        = 128;
  localparam logic [10:0] OTP_LOCK_BASE = 11'h010;

  // Serial framing
  localparam int SPI_ADDR_BYTES   = 3;

  // Byte offsets on the register bus
  localparam logic [3:0] REG_STATUS   = 4'h0;
  localparam logic [3:0] REG_CONFIG   = 4'h4;
  localparam logic [3:0] REG_OTP_ADDR = 4'h8;
  localparam logic [3:0] REG_OTP_DATA = 4'hC;

  // Field positions
  localparam int ST_LATCH  = 1;
  localparam int ST_BP_LO  = 2;
  localparam int ST_EERR   = 5;
  localparam int ST_PERR   = 6;
  localparam int CF_FREEZE = 0;
  localparam int CF_DIR    = 5;
  localparam int OD_ECCOFF = 8;

  // Values after reset
  localparam logic [2:0] BP_RST      = 3'h0;
  localparam logic       DIR_RST     = 1'b0;
  localparam logic       FREEZE_RST  = 1'b0;
  localparam logic [7:0] OTP_BLANK   = 8'hFF;

  // Frame parser states, Gray along idle-address-dummy-data
  typedef enum logic [2:0] {
    FDP_IDLE  = 3'b000,
    FDP_ADDR  = 3'b001,
    FDP_DUMMY = 3'b011,
    FDP_DATA  = 3'b010,
    FDP_SKIP  = 3'b110
  } fdp_state_t;

  typedef struct packed {
    logic        sck;
    logic        csN;
    logic        sdi;
    logic        hwRstN;
  } fdp_pins_t;

  typedef struct packed {
    logic        valid;
    logic        erase;
    logic        whole;
    logic [23:0] addr;
  } fdp_array_req_t;

endpackage : fdp_pkg

// ===== verilog/fdp_pin_sync.sv
// Three-flop pin synchroniser with edge pulses.
// Assumes async pins; a change counts once stages two and three agree.
`timescale 1ns/1ns
`default_nettype none
module fdp_pin_sync #(
  parameter int WIDTH = $bits(fdp_pkg::fdp_pins_t)
) (
  input  wire logic             clock,
  input  wire logic             rstN,
  input  wire logic [WIDTH-1:0] rawIn,
  input  wire logic [WIDTH-1:0] resetLevel,
  output var  logic [WIDTH-1:0] level,
  output var  logic [WIDTH-1:0] rise,
  output var  logic [WIDTH-1:0] fall
);
  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++)
    begin : g_bit
      always_ff @(posedge clock or negedge rstN)
      begin
        if (!rstN)
        begin
          stage1[i] <= 1'b1;
          stage2[i] <= 1'b1;
          stage3[i] <= 1'b1;
        end
        else
        begin
          stage1[i] <= rawIn[i];
          stage2[i] <= stage1[i];
          stage3[i] <= stage2[i];
        end
      end

      always_ff @(posedge clock or negedge rstN)
      begin
        if (!rstN)
        begin
          level[i] <= 1'b1;
          rise[i]  <= 1'b0;
          fall[i]  <= 1'b0;
        end
        else
        begin
          rise[i] <= 1'b0;
          fall[i] <= 1'b0;
          if (stage2[i] == stage3[i] && stage3[i] != level[i])
          begin
            level[i] <= stage3[i];
            rise[i]  <= stage3[i];
            fall[i]  <= ~stage3[i];
          end
        end
      end
    end
  endgenerate

  logic unusedReset;
  assign unusedReset = ^resetLevel;
endmodule : fdp_pin_sync
`default_nettype wire

// ===== verilog/fdp_protect.sv
// Flash protection: one-time space, write latch, block protection.
// Assumes SPI mode 0 pins and an Avalon-MM bus with waitrequest.
// Notes on behaviour
// RULE_01 - One-time space: 2048 bytes, 32 lockable 64-byte regions.
// RULE_02 - One-time read framed as fast read; past 2 kB undefined.
// RULE_03 - One-time program framed as page, repeatable, never erased.
// RULE_04 - First program of a 16-byte unit keeps ECC, a second kills it.
// RULE_05 - Host programs each 16-byte portion once.
// RULE_06 - Out-of-range one-time program ignored; write latch stays set.
// RULE_07 - Frozen: one-time programs fail, program error set.
// RULE_08 - Lock byte bit n guards region n of its eight.
// RULE_09 - Bit zero of lock byte 0x10 guards lock and spare bytes.
// RULE_10 - Host sets the write latch first; device sets it.
// RULE_11 - Write latch clears at reset and after modifying commands.
// RULE_12 - Range-select bits pick the protected fraction.
// RULE_13 - Direction zero protects from the top, one from bottom.
// RULE_14 - Sector protection is block OR guard-bit protection.
// RULE_15 - Host uses one protection scheme only.
// RULE_16 - Freeze holds range and direction bits; unfrozen, writable.
// RULE_17 - Only power-on reset clears freeze.
// RULE_18 - Range writes while frozen are ignored, no error.
// RULE_19 - Either guard bit at zero protects the sector.
// RULE_20 - Programs into a locked one-time region change nothing.
// RULE_21 - Program or erase of a protected sector is refused, reported.
//
// The register offsets and register access over Avalon-MM were decided locally.
`timescale 1ns/1ns
`default_nettype none
module fdp_protect #(
  parameter int         ARRAY_LOG2  = 25,
  parameter int         SECTOR_LOG2 = 17,
  parameter logic [7:0] OPC_LSET    = 8'h06,
  parameter logic [7:0] OPC_LCLR    = 8'h04,
  parameter logic [7:0] OPC_REGWR   = 8'h01,
  parameter logic [7:0] OPC_PAGE    = 8'h02,
  parameter logic [7:0] OPC_QPAGE   = 8'h32,
  parameter logic [7:0] OPC_SECT    = 8'hD8,
  parameter logic [7:0] OPC_BULK    = 8'h60,
  parameter logic [7:0] OPC_SWRST   = 8'hF0,
  parameter logic [7:0] OPC_OTPW    = 8'h42,
  parameter logic [7:0] OPC_OTRD    = 8'h4B,
  parameter int         NSECT       = 1 << (ARRAY_LOG2 - SECTOR_LOG2)
) (
  input  wire logic                   clock,
  input  wire logic                   rst_n,
  input  wire logic [3:0]             avs_address,
  input  wire logic                   avs_read,
  input  wire logic                   avs_write,
  input  wire logic [31:0]            avs_writedata,
  input  wire logic [3:0]             avs_byteenable,
  output var  logic [31:0]            avs_readdata,
  output var  logic                   avs_waitrequest,
  input  wire logic                   spiSck,
  input  wire logic                   spiCsN,
  input  wire logic                   spiSdi,
  output var  logic                   spiSdo,
  input  wire logic                   hwResetN,
  input  wire logic [NSECT-1:0]       persistentGuardBit,
  input  wire logic [NSECT-1:0]       volatileGuardBit,
  output var  fdp_pkg::fdp_array_req_t arrayReq
);
  localparam int SB = ARRAY_LOG2 - SECTOR_LOG2;

  logic [1:0]            rstPipe;
  logic                  rstN;
  fdp_pkg::fdp_pins_t    pinRaw;
  fdp_pkg::fdp_pins_t    pinLvl;
  fdp_pkg::fdp_pins_t    pinRise;
  fdp_pkg::fdp_pins_t    pinFall;
  fdp_pkg::fdp_state_t   state;
  logic [7:0]            otpMem [fdp_pkg::OTP_BYTES];
  logic [fdp_pkg::OTP_UNITS-1:0] unitUsed;
  logic [fdp_pkg::OTP_UNITS-1:0] eccOff;
  logic [6:0]            lastUnit;
  logic                  lastUnitValid;
  logic [7:0]            opcode;
  logic                  haveOpcode;
  logic [2:0]            bitCnt;
  logic [6:0]            rxShift;
  logic [1:0]            addrCnt;
  logic [23:0]           addr;
  logic                  otpStartOk;
  logic [1:0]            regBytes;
  logic [7:0]            regStatusIn;
  logic [7:0]            regConfigIn;
  logic [7:0]            txShift;
  logic                  writeEnableLatch;
  logic [2:0]            rangeSelectBits;
  logic                  rangeDirectionBit;
  logic                  freeze;
  logic                  progErr;
  logic                  eraseErr;
  logic [10:0]           otpAddrSel;
  logic                  hwReset;
  logic                  byteDone;
  logic [7:0]            rxByte;
  logic                  frameEnd;
  logic                  busWrite;
  logic                  otpWrite;
  logic [SB-1:0]         sector;
  logic                  sectorProt;
  logic                  anyProt;
  logic                  pSet;
  logic                  eSet;
  logic                  next_wel;
  fdp_pkg::fdp_array_req_t next_req;
  logic [31:0]           next_rdata;

  // Bytes of a unit never programmed read as blank
  function automatic logic [7:0] otpByte(input logic [23:0] a);
    if (a[23:11] != 13'h0000)
      return fdp_pkg::OTP_BLANK; // RULE_02
    return unitUsed[a[10:4]] ? otpMem[a[10:0]] : fdp_pkg::OTP_BLANK;
  endfunction : otpByte

  function automatic logic otpLocked(input logic [10:0] a);
    logic [4:0] region;
    logic [7:0] lockByte;
    region   = a[10:6];
    lockByte = otpByte({13'h0000, fdp_pkg::OTP_LOCK_BASE + {8'h00, region[4:3]}});
    if (region == 5'h00)
      return (a[5:4] != 2'h0) && !lockByte[0]; // RULE_09
    return !lockByte[region[2:0]]; // RULE_08
  endfunction : otpLocked

  function automatic logic blockHit(input logic [SB-1:0] s, input logic [2:0] bp,
                                    input logic dir);
    int          k;
    logic [SB-1:0] top;
    k   = 7 - int'(bp);
    top = s >> (SB - k);
    if (bp == 3'h0)
      return 1'b0;
    if (bp == 3'h7)
      return 1'b1;
    return dir ? (top == '0) : (top == SB'((1 << k) - 1)); // RULE_12 RULE_13
  endfunction : blockHit

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      rstPipe <= 2'h0;
    else
      rstPipe <= {rstPipe[0], 1'b1};
  end
  assign rstN = rstPipe[1];

  assign pinRaw = '{sck: spiSck, csN: spiCsN, sdi: spiSdi, hwRstN: hwResetN};

  fdp_pin_sync u_pins (
    .clock      (clock),
    .rstN       (rstN),
    .rawIn      (pinRaw),
    .resetLevel ('1),
    .level      (pinLvl),
    .rise       (pinRise),
    .fall       (pinFall)
  );

  assign hwReset  = !pinLvl.hwRstN;
  assign byteDone = pinRise.sck && !pinLvl.csN && bitCnt == 3'h7;
  assign rxByte   = {rxShift, pinLvl.sdi};
  assign frameEnd = pinRise.csN && haveOpcode;
  assign busWrite = avs_write && !avs_waitrequest;
  assign sector   = SB'({8'h00, addr} >> SECTOR_LOG2);
  assign sectorProt = blockHit(sector, rangeSelectBits, rangeDirectionBit)
                    || !persistentGuardBit[sector] || !volatileGuardBit[sector]; // RULE_14 RULE_19
  assign anyProt  = rangeSelectBits != 3'h0 || !(&persistentGuardBit) || !(&volatileGuardBit);
  // Locked, frozen or out-of-range bytes never reach storage
  assign otpWrite = byteDone && state == fdp_pkg::FDP_DATA && opcode == OPC_OTPW
                 && writeEnableLatch && !freeze && otpStartOk && addr[23:11] == 13'h0000
                 && !otpLocked(addr[10:0]); // RULE_06 RULE_07 RULE_20

  // Frame parser: opcode, address, dummy, data
  always_ff @(posedge clock or negedge rstN)
  begin
    if (!rstN)
    begin
      state       <= fdp_pkg::FDP_IDLE;
      opcode      <= 8'h00;
      haveOpcode  <= 1'b0;
      bitCnt      <= 3'h0;
      rxShift     <= 7'h00;
      addrCnt     <= 2'h0;
      addr        <= 24'h000000;
      otpStartOk  <= 1'b0;
      regBytes    <= 2'h0;
      regStatusIn <= 8'h00;
      regConfigIn <= 8'h00;
    end
    else if (hwReset || pinFall.csN || pinRise.csN)
    begin
      state      <= fdp_pkg::FDP_IDLE;
      haveOpcode <= 1'b0;
      bitCnt     <= 3'h0;
      addrCnt    <= 2'h0;
      regBytes   <= 2'h0;
    end
    else if (pinRise.sck && !pinLvl.csN)
    begin
      bitCnt  <= bitCnt + 3'h1;
      rxShift <= rxByte[6:0];
      if (byteDone)
      begin
        unique case (state)
          fdp_pkg::FDP_IDLE:
          begin
            opcode     <= rxByte;
            haveOpcode <= 1'b1;
            if (rxByte == OPC_REGWR)
              state <= fdp_pkg::FDP_DATA;
            else if (rxByte == OPC_PAGE || rxByte == OPC_QPAGE || rxByte == OPC_SECT
                     || rxByte == OPC_OTPW || rxByte == OPC_OTRD)
              state <= fdp_pkg::FDP_ADDR;
            else
              state <= fdp_pkg::FDP_SKIP;
          end
          fdp_pkg::FDP_ADDR:
          begin
            addr    <= {addr[15:0], rxByte};
            addrCnt <= addrCnt + 2'h1;
            if (addrCnt == 2'(fdp_pkg::SPI_ADDR_BYTES - 1))
            begin
              otpStartOk <= addr[15:3] == 13'h0000; // RULE_06
              if (opcode == OPC_OTRD)
                state <= fdp_pkg::FDP_DUMMY; // RULE_02
              else if (opcode == OPC_SECT)
                state <= fdp_pkg::FDP_SKIP;
              else
                state <= fdp_pkg::FDP_DATA; // RULE_03
            end
          end
          fdp_pkg::FDP_DUMMY:
            state <= fdp_pkg::FDP_DATA;
          fdp_pkg::FDP_DATA:
          begin
            if (opcode == OPC_REGWR)
            begin
              if (regBytes == 2'h0)
                regStatusIn <= rxByte;
              else if (regBytes == 2'h1)
                regConfigIn <= rxByte;
              if (regBytes != 2'h2)
                regBytes <= regBytes + 2'h1;
            end
            else if (opcode == OPC_OTPW || opcode == OPC_OTRD)
              addr <= addr + 24'h000001;
          end
          fdp_pkg::FDP_SKIP:
            state <= fdp_pkg::FDP_SKIP;
        endcase
      end
    end
  end

  // No erase path; a unit's first program blanks its other bytes
  always_ff @(posedge clock)
  begin
    if (otpWrite)
      for (int j = 0; j < (1 << fdp_pkg::OTP_UNIT_LOG2); j++)
        if (addr[3:0] == 4'(j))
          otpMem[addr[10:0]] <= rxByte & otpByte(addr); // RULE_01 RULE_03
        else if (!unitUsed[addr[10:4]])
          otpMem[{addr[10:4], 4'(j)}] <= fdp_pkg::OTP_BLANK;
  end

  // Repeat writes within one command count as a single program of the unit
  always_ff @(posedge clock or negedge rstN)
  begin
    if (!rstN)
    begin
      unitUsed      <= '0;
      eccOff        <= '0;
      lastUnit      <= 7'h00;
      lastUnitValid <= 1'b0;
    end
    else if (pinFall.csN)
      lastUnitValid <= 1'b0;
    else if (otpWrite)
    begin
      unitUsed[addr[10:4]] <= 1'b1;
      if (unitUsed[addr[10:4]] && !(lastUnitValid && lastUnit == addr[10:4]))
        eccOff[addr[10:4]] <= 1'b1; // RULE_04
      lastUnit      <= addr[10:4];
      lastUnitValid <= 1'b1;
    end
  end

  // Data shifts out after each falling clock so it is stable at the rising edge
  always_ff @(posedge clock or negedge rstN)
  begin
    if (!rstN)
    begin
      txShift <= 8'h00;
      spiSdo  <= 1'b0;
    end
    else if (byteDone && opcode == OPC_OTRD
             && (state == fdp_pkg::FDP_DUMMY || state == fdp_pkg::FDP_DATA))
      txShift <= otpByte(state == fdp_pkg::FDP_DATA ? addr + 24'h000001 : addr); // RULE_02
    else if (pinFall.sck && !pinLvl.csN && state == fdp_pkg::FDP_DATA && opcode == OPC_OTRD)
    begin
      spiSdo  <= txShift[7];
      txShift <= {txShift[6:0], 1'b0};
    end
    else if (pinLvl.csN)
      spiSdo <= 1'b0;
  end

  // Effects at the end of a frame
  always_comb
  begin
    next_wel = writeEnableLatch;
    pSet     = 1'b0;
    eSet     = 1'b0;
    next_req = '{valid: 1'b0, erase: 1'b0, whole: 1'b0, addr: addr};
    if (frameEnd)
    begin
      if (opcode == OPC_LSET)
        next_wel = 1'b1; // RULE_10
      else if (opcode == OPC_LCLR || opcode == OPC_SWRST)
        next_wel = 1'b0; // RULE_11
      else if (writeEnableLatch)
      begin
        if (opcode == OPC_PAGE || opcode == OPC_QPAGE)
        begin
          pSet           = sectorProt; // RULE_21
          next_req.valid = !sectorProt;
          next_wel       = 1'b0; // RULE_11
        end
        else if (opcode == OPC_SECT || opcode == OPC_BULK)
        begin
          eSet           = opcode == OPC_BULK ? anyProt : sectorProt; // RULE_21
          next_req.valid = !eSet;
          next_req.erase = 1'b1;
          next_req.whole = opcode == OPC_BULK;
          next_wel       = 1'b0; // RULE_11
        end
        else if (opcode == OPC_OTPW)
        begin
          pSet = freeze; // RULE_07
          if (!otpStartOk && !freeze)
            next_wel = 1'b1; // RULE_06
          else
            next_wel = 1'b0; // RULE_11
        end
        else if (opcode == OPC_REGWR && regBytes != 2'h0)
          next_wel = 1'b0; // RULE_11
      end
    end
  end

  always_ff @(posedge clock or negedge rstN)
  begin
    if (!rstN)
    begin
      writeEnableLatch <= 1'b0;
      progErr          <= 1'b0;
      eraseErr         <= 1'b0;
      arrayReq         <= '0;
    end
    else if (hwReset)
    begin
      writeEnableLatch <= 1'b0; // RULE_11
      progErr          <= 1'b0;
      eraseErr         <= 1'b0;
      arrayReq         <= '0;
    end
    else
    begin
      writeEnableLatch <= next_wel;
      arrayReq         <= next_req;
      // A new error wins over a clear in the same cycle
      progErr  <= pSet || (progErr && !(busWrite && avs_address == fdp_pkg::REG_STATUS
                  && avs_byteenable[0] && avs_writedata[fdp_pkg::ST_PERR]));
      eraseErr <= eSet || (eraseErr && !(busWrite && avs_address == fdp_pkg::REG_STATUS
                  && avs_byteenable[0] && avs_writedata[fdp_pkg::ST_EERR]));
    end
  end

  // Freeze survives the hardware reset pin; only the power-on reset clears it
  always_ff @(posedge clock or negedge rstN)
  begin
    if (!rstN)
    begin
      rangeSelectBits   <= fdp_pkg::BP_RST;
      rangeDirectionBit <= fdp_pkg::DIR_RST;
      freeze            <= fdp_pkg::FREEZE_RST; // RULE_17
    end
    else if (frameEnd && opcode == OPC_REGWR && writeEnableLatch && regBytes != 2'h0)
    begin
      if (!freeze)
      begin
        rangeSelectBits <= regStatusIn[fdp_pkg::ST_BP_LO +: 3]; // RULE_16 RULE_18
        if (regBytes == 2'h2)
          rangeDirectionBit <= regConfigIn[fdp_pkg::CF_DIR]; // RULE_16
      end
      if (regBytes == 2'h2 && regConfigIn[fdp_pkg::CF_FREEZE])
        freeze <= 1'b1; // RULE_17
    end
  end

  always_ff @(posedge clock or negedge rstN)
  begin
    if (!rstN)
      otpAddrSel <= 11'h000;
    else if (busWrite && avs_address == fdp_pkg::REG_OTP_ADDR)
    begin
      if (avs_byteenable[0])
        otpAddrSel[7:0] <= avs_writedata[7:0];
      if (avs_byteenable[1])
        otpAddrSel[10:8] <= avs_writedata[10:8];
    end
  end

  always_comb
  begin
    next_rdata = 32'h00000000;
    unique case (avs_address)
      fdp_pkg::REG_STATUS:
      begin
        next_rdata[fdp_pkg::ST_LATCH]      = writeEnableLatch;
        next_rdata[fdp_pkg::ST_BP_LO +: 3] = rangeSelectBits;
        next_rdata[fdp_pkg::ST_EERR]       = eraseErr;
        next_rdata[fdp_pkg::ST_PERR]       = progErr;
      end
      fdp_pkg::REG_CONFIG:
      begin
        next_rdata[fdp_pkg::CF_FREEZE] = freeze;
        next_rdata[fdp_pkg::CF_DIR]    = rangeDirectionBit;
      end
      fdp_pkg::REG_OTP_ADDR:
        next_rdata[10:0] = otpAddrSel;
      fdp_pkg::REG_OTP_DATA:
      begin
        next_rdata[7:0]                = otpByte({13'h0000, otpAddrSel});
        next_rdata[fdp_pkg::OD_ECCOFF] = eccOff[otpAddrSel[10:4]];
      end
      default:
        next_rdata = 32'h00000000;
    endcase
  end

  // One wait state per access; unmapped offsets read zero and ignore writes
  always_ff @(posedge clock or negedge rstN)
  begin
    if (!rstN)
    begin
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h00000000;
    end
    else if (avs_waitrequest && (avs_read || avs_write))
    begin
      avs_waitrequest <= 1'b0;
      avs_readdata    <= avs_read ? next_rdata : 32'h00000000;
    end
    else
      avs_waitrequest <= 1'b1;
  end

endmodule : fdp_protect
`default_nettype wire

// ===== testbench/fdp_protect_monitor.sv
// Checker on the protection block's ports.
// Assumes one clock domain.
`timescale 1ns/1ns
`default_nettype none
module fdp_protect_monitor #(
  parameter int NSECT       = 256,
  parameter int SECTOR_LOG2 = 17
) (
  input wire logic                    clock,
  input wire logic                    rst_n,
  input wire logic [3:0]              avs_address,
  input wire logic                    avs_read,
  input wire logic                    avs_write,
  input wire logic [31:0]             avs_readdata,
  input wire logic                    avs_waitrequest,
  input wire logic                    spiCsN,
  input wire logic                    spiSdo,
  input wire logic [NSECT-1:0]        persistentGuardBit,
  input wire logic [NSECT-1:0]        volatileGuardBit,
  input wire fdp_pkg::fdp_array_req_t arrayReq
);
  wire logic [23:0] sect = arrayReq.addr >> SECTOR_LOG2;
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);
  sequence s_req;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence
  sequence s_ans;
    !avs_waitrequest ##1 avs_waitrequest;
  endsequence
  chk_bus_answer: assert property (s_req |-> ##[1:2] s_ans)
    else $error("bus answer late");
  chk_wait_cause: assert property ($fell(avs_waitrequest) |-> $past(avs_read || avs_write))
    else $error("answer without request");
  chk_unmapped_zero: assert property (!avs_waitrequest && avs_read && avs_address[1:0] != 2'h0
    |-> avs_readdata == 32'h0) else $error("unmapped read not zero");
  chk_config_rsvd: assert property (!avs_waitrequest && avs_read
    && avs_address == fdp_pkg::REG_CONFIG |-> (avs_readdata & 32'hFFFFFFDE) == 32'h0)
    else $error("config spare bits set");
  chk_req_pulse: assert property (arrayReq.valid |=> !arrayReq.valid)
    else $error("array request too long");
  chk_req_frame: assert property (arrayReq.valid |-> spiCsN && $past(spiCsN, 3))
    else $error("array request inside frame");
  chk_sector_guard: assert property (arrayReq.valid && !arrayReq.whole
    |-> persistentGuardBit[sect] && volatileGuardBit[sect]) else $error("guarded sector hit");
  chk_whole_guard: assert property (arrayReq.valid && arrayReq.whole
    |-> &persistentGuardBit && &volatileGuardBit) else $error("guarded wipe passed");
  chk_sdo_quiet: assert property (spiCsN [*6] |-> !spiSdo)
    else $error("serial out busy when idle");
endmodule : fdp_protect_monitor
bind fdp_protect fdp_protect_monitor #(.NSECT(NSECT), .SECTOR_LOG2(SECTOR_LOG2)) mon_u (
  .clock(clock), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .spiCsN(spiCsN), .spiSdo(spiSdo), .persistentGuardBit(persistentGuardBit),
  .volatileGuardBit(volatileGuardBit), .arrayReq(arrayReq));
`default_nettype wire

// ===== testbench/fdp_host_model.sv
// Host model: mode 0 frames, 125 ns clock.
// Assumes the device oversamples its pins.
`timescale 1ns/1ns
`default_nettype none
module fdp_host_model (
  output var logic sck,
  output var logic csN,
  output var logic sdi
);
  initial
  begin
    sck = 1'b0;
    csN = 1'b1;
    sdi = 1'b0;
  end
  // Clock only runs inside a frame; bytes go out MSB first
  task automatic send(input logic [7:0] b[$]);
    csN = 1'b0;
    #70;
    foreach (b[i])
      for (int k = 7; k >= 0; k--)
      begin
        sdi = b[i][k];
        #62 sck = 1'b1;
        #63 sck = 1'b0;
      end
    #40 csN = 1'b1;
    sdi = ~sdi;
  endtask : send
endmodule : fdp_host_model
`default_nettype wire

// ===== testbench/testbench.sv
// Self-checking bench, one task per scenario.
// Assumes host model and checker compiled with it.
`timescale 1ns/1ns
`default_nettype none
module testbench;
  localparam logic [3:0] ST = fdp_pkg::REG_STATUS;
  localparam logic [3:0] CF = fdp_pkg::REG_CONFIG;
  logic                    clock, rst_n, hwResetN, rdq, wrq, wreq, sdo;
  logic [3:0]              adr;
  logic [31:0]             wdat, rdat, rd;
  logic [255:0]            pG, vG;
  wire logic               sck, csN, sdi;
  fdp_pkg::fdp_array_req_t arrayReq;
  int                      failures, n_compared, reqs;
  fdp_protect dut_u (.clock(clock), .rst_n(rst_n), .avs_address(adr), .avs_read(rdq),
    .avs_write(wrq), .avs_writedata(wdat), .avs_byteenable(4'hF), .avs_readdata(rdat),
    .avs_waitrequest(wreq), .spiSck(sck), .spiCsN(csN), .spiSdi(sdi), .spiSdo(sdo),
    .hwResetN(hwResetN), .persistentGuardBit(pG), .volatileGuardBit(vG),
    .arrayReq(arrayReq));
  fdp_host_model host_u (.sck(sck), .csN(csN), .sdi(sdi));
  initial
  begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  always @(posedge clock)
    if (arrayReq.valid === 1'b1)
      reqs++;
  task automatic wrap_up();
    $display("Compared %0d, mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : wrap_up
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n;
    @(posedge clock);
    rdq <= !w;
    wrq <= w;
    adr <= a;
    wdat <= d;
    n = 0;
    do
    begin
      @(posedge clock);
      n++;
    end
    while (wreq !== 1'b0 && n < 40);
    rd = rdat;
    rdq <= 1'b0;
    wrq <= 1'b0;
    if (n >= 40)
    begin
      failures++;
      wrap_up();
    end
  endtask : bus
  task automatic frame(input logic [7:0] b[$]);
    host_u.send(b);
    repeat (12) @(posedge clock);
  endtask : frame
  task automatic wop(input logic [7:0] b[$]);
    frame('{8'h06});
    frame(b);
  endtask : wop
  task automatic otp(input logic [10:0] a);
    bus(1'b1, fdp_pkg::REG_OTP_ADDR, {21'h0, a});
    bus(1'b0, fdp_pkg::REG_OTP_DATA, 32'h0);
  endtask : otp
  task automatic t_reset();
    bus(1'b1, 4'h6, 32'hFF);
    bus(1'b0, ST, 0);
    check("status", rd, 32'h0);
    bus(1'b0, CF, 0);
    check("config", rd, 32'h0);
    bus(1'b0, 4'h2, 0);
    check("unmapped", rd, 32'h0);
    otp(11'h7FF);
    check("blank", rd[8:0], 9'h0FF);
    $display("reset test done");
  endtask : t_reset
  task automatic t_latch();
    logic [7:0] opc [7] = '{8'h04, 8'hF0, 8'h01, 8'h02, 8'h32, 8'hD8, 8'h60};
    frame('{8'h02, 8'h00, 8'h10, 8'h00});
    check("unlatched", reqs, 0);
    foreach (opc[i])
    begin
      frame('{8'h06});
      bus(1'b0, ST, 0);
      check("latch set", rd[1], 1);
      frame('{opc[i], 8'h00, 8'h00, 8'h00});
      bus(1'b0, ST, 0);
      check("latch clear", rd[1], 0);
    end
    check("requests", reqs, 4);
    $display("latch test done");
  endtask : t_latch
  task automatic t_otp();
    wop('{8'h42, 8'h00, 8'h01, 8'h00, 8'hA5});
    otp(11'h100);
    check("first", rd[8:0], 9'h0A5);
    wop('{8'h42, 8'h00, 8'h01, 8'h01, 8'h3C});
    otp(11'h101);
    check("second", rd[8:0], 9'h13C);
    wop('{8'h42, 8'h00, 8'h08, 8'h00, 8'h00});
    bus(1'b0, ST, 0);
    check("range latch", rd[1], 1);
    otp(11'h000);
    check("range data", rd[7:0], 8'hFF);
    wop('{8'h42, 8'h00, 8'h00, 8'h10, 8'hFD});
    wop('{8'h42, 8'h00, 8'h00, 8'h40, 8'h00});
    otp(11'h040);
    check("locked", rd[7:0], 8'hFF);
    wop('{8'h42, 8'h00, 8'h00, 8'h80, 8'h00});
    otp(11'h080);
    check("open", rd[7:0], 8'h00);
    wop('{8'h42, 8'h00, 8'h00, 8'h10, 8'hFC});
    wop('{8'h42, 8'h00, 8'h00, 8'h11, 8'h00});
    otp(11'h011);
    check("lock bytes", rd[7:0], 8'hFF);
    $display("one-time test done");
  endtask : t_otp
  task automatic t_guard();
    reqs = 0;
    vG[96] <= 1'b0;
    wop('{8'hD8, 8'hC0, 8'h00, 8'h00});
    vG[96] <= 1'b1;
    pG[3] <= 1'b0;
    wop('{8'h60});
    bus(1'b0, ST, 0);
    check("guard err", rd[5], 1);
    check("guard req", reqs, 0);
    pG[3] <= 1'b1;
    bus(1'b1, ST, 32'h60);
    bus(1'b0, ST, 0);
    check("w1c", rd[6:5], 0);
    $display("guard test done");
  endtask : t_guard
  task automatic t_range();
    wop('{8'h01, 8'h14, 8'h20});
    bus(1'b0, CF, 0);
    check("dir", rd, 32'h20);
    wop('{8'hD8, 8'h00, 8'h00, 8'h00});
    wop('{8'hD8, 8'hC0, 8'h00, 8'h00});
    bus(1'b0, ST, 0);
    check("range", rd[5:2], 4'hD);
    check("bottom", reqs, 1);
    bus(1'b1, ST, 32'h60);
    wop('{8'h01, 8'h14, 8'h21});
    wop('{8'h01, 8'h00, 8'h00});
    bus(1'b0, ST, 0);
    check("frozen bits", rd[6:2], 5'h05);
    hwResetN <= 1'b0;
    repeat (10) @(posedge clock);
    hwResetN <= 1'b1;
    repeat (10) @(posedge clock);
    bus(1'b0, CF, 0);
    check("freeze kept", rd, 32'h21);
    wop('{8'h42, 8'h00, 8'h02, 8'h00, 8'h00});
    bus(1'b0, ST, 0);
    check("frozen otp", rd[6], 1);
    otp(11'h200);
    check("otp kept", rd[7:0], 8'hFF);
    $display("range test done");
  endtask : t_range
  initial
  begin
    {rst_n, rdq, wrq, adr, wdat, failures, n_compared, reqs} = '0;
    hwResetN = 1'b1;
    pG = '1;
    vG = '1;
    repeat (5) @(posedge clock);
    rst_n <= 1'b1;
    repeat (8) @(posedge clock);
    t_reset();
    t_latch();
    t_otp();
    t_guard();
    t_range();
    wrap_up();
  end
endmodule : testbench
`default_nettype wire
